// File: verilog/boost_ctrl_pkg.sv
// Purpose: Shared constants and types for the boost converter switch control
// Assumes: 50 MHz system clock, register port at the printed 10-bit offsets
// Notes: Field positions inside registers are local choices where none is printed
package boost_ctrl_pkg;

   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;

   // Register offsets
   localparam logic [9:0] OFF_LAUNCH_A = 10'h100;
   localparam logic [9:0] OFF_LAUNCH_B = 10'h120;
   localparam logic [9:0] OFF_LEVEL = 10'h19B;
   localparam logic [9:0] OFF_FILTER = 10'h19D;
   localparam logic [9:0] OFF_DRV_CFG = 10'h1C5;
   localparam logic [9:0] OFF_CLK_HANDLING = 10'h1C7;

   // Field positions
   localparam int LAUNCH_BIT = 0;
   localparam int OVR_BIT = 0;
   localparam int FILT_TYPE_BIT = 8;
   localparam int CLK_POLICY_BIT = 0;
   localparam int CLK_MISSING_BIT = 1;
   localparam int CLK_BACKUP_BIT = 2;

   // Values after reset
   localparam logic [7:0] LEVEL_RST = 8'h00;
   localparam logic [7:0] FILT_TIME_RST = 8'h0A;
   localparam logic FILT_TYPE_RST = 1'b0;
   localparam logic OVR_RST = 1'b1;
   localparam logic CLK_POLICY_RST = 1'b1;

   // Timing
   localparam int CLK_PERIOD_PS = 20000;
   localparam int UV_FILTER_PS = 1300000;
   localparam int UV_FILTER_CYC = (UV_FILTER_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int UV_CNT_W = 7;

   // Comparator outputs from the analog front end
   typedef struct packed {
      logic boost_above;
      logic cur_low;
      logic cur_high;
      logic cur_neg;
   } cmp_t;

   // Current comparator threshold levels
   typedef struct packed {
      logic [4:0] low_current_level;
      logic [4:0] high_current_level;
      logic [4:0] negative_current_level;
   } cur_levels_t;

   // Pins passing the synchroniser
   typedef struct packed {
      logic batt_ok;
      logic gate_supply_undervoltage;
      logic logic_supply_undervoltage;
      logic drive_enable;
      logic clock_missing;
      logic on_backup_clock;
      cmp_t cmp;
   } pins_t;

   localparam pins_t PINS_RST = '{batt_ok: 1'b0, gate_supply_undervoltage: 1'b1,
      logic_supply_undervoltage: 1'b1, drive_enable: 1'b0, clock_missing: 1'b0,
      on_backup_clock: 1'b0, cmp: 4'h0};

endpackage : boost_ctrl_pkg

// File: verilog/boost_converter_switch_control.sv
// Purpose: Boost converter regulation and switch gate command generation
// Assumes: Analog and pin inputs are asynchronous; microcore inputs share CLOCK_I
// Notes: Register reads return data one cycle after REG_RD_I; writes take effect next edge
`timescale 1ns/100ps

module boost_converter_switch_control
(
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic [boost_ctrl_pkg::ADDR_W-1:0] REG_ADDR_I,
   input wire logic [boost_ctrl_pkg::DATA_W-1:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [boost_ctrl_pkg::DATA_W-1:0] REG_RDATA_O,
   input wire logic BATT_OK_I,
   input wire logic GATE_SUPPLY_UNDERVOLTAGE_I,
   input wire logic LOGIC_SUPPLY_UNDERVOLTAGE_I,
   input wire logic DRIVE_ENABLE_I,
   input wire logic CLOCK_MISSING_I,
   input wire logic ON_BACKUP_CLOCK_I,
   input wire boost_ctrl_pkg::cmp_t BOOST_CMP_I,
   input wire logic VAR_FREQ_MODE_I,
   input wire logic BOOST_RUN_I,
   input wire logic CHANNEL_SWITCH_REQUEST_I,
   input wire boost_ctrl_pkg::cur_levels_t CUR_LEVELS_I,
   output logic SWITCH_GATE_COMMAND_O,
   output boost_ctrl_pkg::cur_levels_t CUR_LEVELS_O,
   output logic [7:0] BOOST_LEVEL_O,
   output logic BOOST_ABOVE_O,
   output logic FILTER_SETTLED_O,
   output logic NEG_OVERCURRENT_O,
   output logic CODE_LAUNCH_O
);
   import boost_ctrl_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [9:0] off);
      hit = (addr == off);
   endfunction : hit

   pins_t pins_raw;
   pins_t sync1_q;
   pins_t sync2_q;
   logic launch_a_q;
   logic launch_b_q;
   logic launch_q;
   logic [7:0] level_q;
   logic [7:0] filt_time_q;
   logic filt_type_q;
   logic ovr_q;
   logic clk_policy_q;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] rdata_q;
   logic [7:0] settle_cnt_q;
   logic settled_q;
   logic above_q;
   logic [UV_CNT_W-1:0] uv_cnt_q;
   logic uv_filt_q;
   logic vf_on_q;
   logic regulate;
   logic chan_req;
   logic clock_permit;
   logic permit;
   logic gate_d;
   logic gate_q;
   logic neg_oc_q;
   cur_levels_t levels_q;

   assign pins_raw = '{batt_ok: BATT_OK_I,
      gate_supply_undervoltage: GATE_SUPPLY_UNDERVOLTAGE_I,
      logic_supply_undervoltage: LOGIC_SUPPLY_UNDERVOLTAGE_I,
      drive_enable: DRIVE_ENABLE_I, clock_missing: CLOCK_MISSING_I,
      on_backup_clock: ON_BACKUP_CLOCK_I, cmp: BOOST_CMP_I};

   // Two-stage synchroniser for every asynchronous pin
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         sync1_q <= PINS_RST;
         sync2_q <= PINS_RST;
      end
      else
      begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   // Register writes
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         launch_a_q <= 1'b0;
         launch_b_q <= 1'b0;
         level_q <= LEVEL_RST;
         filt_time_q <= FILT_TIME_RST;
         filt_type_q <= FILT_TYPE_RST;
         ovr_q <= OVR_RST;
         clk_policy_q <= CLK_POLICY_RST;
      end
      else if (REG_WR_I)
      begin
         if (hit(REG_ADDR_I, OFF_LAUNCH_A))
            launch_a_q <= REG_WDATA_I[LAUNCH_BIT];
         if (hit(REG_ADDR_I, OFF_LAUNCH_B))
            launch_b_q <= REG_WDATA_I[LAUNCH_BIT];
         if (hit(REG_ADDR_I, OFF_LEVEL))
            level_q <= REG_WDATA_I[7:0];
         if (hit(REG_ADDR_I, OFF_FILTER))
         begin
            filt_time_q <= REG_WDATA_I[7:0];
            filt_type_q <= REG_WDATA_I[FILT_TYPE_BIT];
         end
         if (hit(REG_ADDR_I, OFF_DRV_CFG))
            ovr_q <= REG_WDATA_I[OVR_BIT];
         if (hit(REG_ADDR_I, OFF_CLK_HANDLING))
            clk_policy_q <= REG_WDATA_I[CLK_POLICY_BIT];
      end
   end

   // Either launch bit starts the code; one flop feeds the gate path and the output
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
         launch_q <= 1'b0;
      else
         launch_q <= launch_a_q || launch_b_q;
   end

   // Register reads; unmapped offsets read zero
   always_comb
   begin
      rdata_d = '0;
      if (hit(REG_ADDR_I, OFF_LAUNCH_A))
         rdata_d[LAUNCH_BIT] = launch_a_q;
      if (hit(REG_ADDR_I, OFF_LAUNCH_B))
         rdata_d[LAUNCH_BIT] = launch_b_q;
      if (hit(REG_ADDR_I, OFF_LEVEL))
         rdata_d[7:0] = level_q;
      if (hit(REG_ADDR_I, OFF_FILTER))
      begin
         rdata_d[7:0] = filt_time_q;
         rdata_d[FILT_TYPE_BIT] = filt_type_q;
      end
      if (hit(REG_ADDR_I, OFF_DRV_CFG))
         rdata_d[OVR_BIT] = ovr_q;
      if (hit(REG_ADDR_I, OFF_CLK_HANDLING))
      begin
         rdata_d[CLK_POLICY_BIT] = clk_policy_q;
         rdata_d[CLK_MISSING_BIT] = sync2_q.clock_missing;
         rdata_d[CLK_BACKUP_BIT] = sync2_q.on_backup_clock;
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
         rdata_q <= '0;
      else if (REG_RD_I)
         rdata_q <= rdata_d;
   end

   // Boost voltage comparator filter; a new target restarts the settle time
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         settle_cnt_q <= 8'h00;
         settled_q <= 1'b0;
         above_q <= 1'b0;
      end
      else if (REG_WR_I && hit(REG_ADDR_I, OFF_LEVEL))
      begin
         settle_cnt_q <= filt_time_q;
         settled_q <= 1'b0;
      end
      else if (sync2_q.cmp.boost_above == above_q)
      begin
         // Once settled, keep the count full so every crossing but a type 1 fall waits the whole time
         if (settled_q)
            settle_cnt_q <= filt_time_q;
         else if (settle_cnt_q == 8'h00)
            settled_q <= 1'b1;
         else
            settle_cnt_q <= settle_cnt_q - 8'h01;
      end
      else if (filt_type_q && !sync2_q.cmp.boost_above)
      begin
         // Type 1 filters only the rising crossing; a fall is taken at once
         above_q <= 1'b0;
         settle_cnt_q <= filt_time_q;
      end
      else if (settle_cnt_q == 8'h00)
      begin
         above_q <= sync2_q.cmp.boost_above;
         settle_cnt_q <= filt_time_q;
         settled_q <= 1'b1;
      end
      else
      begin
         settle_cnt_q <= settle_cnt_q - 8'h01;
         settled_q <= 1'b0;
      end
   end

   // Gate supply recovery filter
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || sync2_q.gate_supply_undervoltage)
      begin
         uv_filt_q <= 1'b1;
         uv_cnt_q <= '0;
      end
      else if (uv_cnt_q == UV_CNT_W'(UV_FILTER_CYC - 1))
         uv_filt_q <= 1'b0;
      else
         uv_cnt_q <= uv_cnt_q + UV_CNT_W'(1);
   end

   // Variable-frequency hysteretic current loop
   assign regulate = BOOST_RUN_I && VAR_FREQ_MODE_I && settled_q;

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || !regulate || above_q)
         vf_on_q <= 1'b0;
      else if (sync2_q.cmp.cur_high)
         vf_on_q <= 1'b0;
      else if (sync2_q.cmp.cur_low)
         vf_on_q <= 1'b1;
   end

   // Fixed mode takes the microcode's timed request directly
   assign chan_req = VAR_FREQ_MODE_I ? vf_on_q : CHANNEL_SWITCH_REQUEST_I;
   assign clock_permit = !(sync2_q.clock_missing && !sync2_q.on_backup_clock
      && clk_policy_q);
   // No fault detection is fed back from the pre-driver path
   assign permit = sync2_q.batt_ok && launch_q && !uv_filt_q
      && !sync2_q.logic_supply_undervoltage && clock_permit
      && (sync2_q.drive_enable || ovr_q);
   assign gate_d = permit && chan_req;

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
         gate_q <= 1'b0;
      else
         gate_q <= gate_d;
   end

   // Threshold levels and negative overcurrent flag
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         levels_q <= '0;
         neg_oc_q <= 1'b0;
      end
      else
      begin
         levels_q <= CUR_LEVELS_I;
         neg_oc_q <= VAR_FREQ_MODE_I && sync2_q.cmp.cur_neg;
      end
   end

   assign REG_RDATA_O = rdata_q;
   assign SWITCH_GATE_COMMAND_O = gate_q;
   assign CUR_LEVELS_O = levels_q;
   assign BOOST_LEVEL_O = level_q;
   assign BOOST_ABOVE_O = above_q;
   assign FILTER_SETTLED_O = settled_q;
   assign NEG_OVERCURRENT_O = neg_oc_q;
   assign CODE_LAUNCH_O = launch_q;

   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);

   a_batt_low_off: assert property (!sync2_q.batt_ok |=> !SWITCH_GATE_COMMAND_O)
      else $error("gate on with battery low");
   a_gate_uv_off: assert property (uv_filt_q |=> !SWITCH_GATE_COMMAND_O)
      else $error("gate on during gate supply undervoltage");
   a_enable_pin_gate: assert property (SWITCH_GATE_COMMAND_O
      |-> $past(sync2_q.drive_enable || ovr_q))
      else $error("gate on with enable pin low and no override");
   a_gate_full_cond: assert property (SWITCH_GATE_COMMAND_O |-> $past(chan_req)
      && !$past(sync2_q.logic_supply_undervoltage))
      else $error("gate on without request or with logic undervoltage");
   a_clock_missing_off: assert property ((sync2_q.clock_missing
      && !sync2_q.on_backup_clock && clk_policy_q) |=> !SWITCH_GATE_COMMAND_O)
      else $error("gate on with missing clock");
   a_uv_recover_time: assert property ($fell(uv_filt_q)
      |-> $past(!sync2_q.gate_supply_undervoltage, 2)
      && $past(uv_cnt_q) == UV_CNT_W'(UV_FILTER_CYC - 1))
      else $error("gate supply recovery filter wrong length");
   a_gate_one_stage: assert property (gate_d |=> SWITCH_GATE_COMMAND_O)
      else $error("gate command not registered in one cycle");
   a_above_stops_vf: assert property (above_q |=> !vf_on_q ##1 !SWITCH_GATE_COMMAND_O
      or !VAR_FREQ_MODE_I)
      else $error("switching continued above window");
   a_vf_current_on: assert property (regulate && !above_q && sync2_q.cmp.cur_low
      && !sync2_q.cmp.cur_high |=> vf_on_q)
      else $error("current loop failed to turn on");
   a_neg_var_only: assert property (NEG_OVERCURRENT_O |-> $past(VAR_FREQ_MODE_I))
      else $error("negative overcurrent outside variable mode");
   a_no_launch_off: assert property (!CODE_LAUNCH_O |=> !SWITCH_GATE_COMMAND_O)
      else $error("gate on before code launch");
   a_level_resettle: assert property (REG_WR_I && hit(REG_ADDR_I, OFF_LEVEL)
      |=> !FILTER_SETTLED_O)
      else $error("settled flag kept after new target");
   a_fast_fall_clear: assert property (filt_type_q && above_q && !sync2_q.cmp.boost_above
      && !(REG_WR_I && hit(REG_ADDR_I, OFF_LEVEL)) |=> !BOOST_ABOVE_O)
      else $error("falling crossing not taken at once with filter type set");

   c_vf_cycle: cover property (vf_on_q ##1 !vf_on_q ##[1:50] vf_on_q);
   c_fixed_on: cover property (!VAR_FREQ_MODE_I && SWITCH_GATE_COMMAND_O);
   c_uv_recover: cover property ($fell(uv_filt_q));
   c_above_stop: cover property ($rose(above_q) && VAR_FREQ_MODE_I);

endmodule : boost_converter_switch_control

// File: test/boost_plant.sv
// Purpose: Behavioural boost plant: switch, inductor, sense resistor, comparators
// Assumes: Current climbs one step per clock while the switch conducts
// Notes: No load on the output, so once above the window it stays there
`timescale 1ns/100ps
module boost_plant
   import boost_ctrl_pkg::*;
#(
   parameter int LOW_LIM = 2,
   parameter int HIGH_LIM = 6,
   parameter int V_TOP = 100
)
(
   input wire logic clk_i,
   input wire logic clr_i,
   input wire logic gate_i,
   input wire logic inject_i,
   output cmp_t cmp_o
);
   logic [5:0] cur_q;
   logic [7:0] volt_q;
   always_ff @(posedge clk_i)
   begin
      if (clr_i)
      begin
         cur_q <= 6'h00;
         volt_q <= 8'h00;
      end
      else if (gate_i && cur_q != 6'h3F)
         cur_q <= cur_q + 6'h01;
      else if (!gate_i && cur_q != 6'h00)
      begin
         cur_q <= cur_q - 6'h01;
         volt_q <= volt_q + 8'h01;   // Inductor discharge lifts the output
      end
   end
   assign cmp_o = '{boost_above: (volt_q > V_TOP), cur_low: (cur_q < LOW_LIM),
      cur_high: (cur_q > HIGH_LIM), cur_neg: inject_i};
endmodule : boost_plant

// File: test/boost_converter_switch_control_tb_top.sv
// Purpose: Self-checking bench for the boost switch control block
// Assumes: Inputs change 1 ns after the rising edge of a 50 MHz clock
// Notes: The variable-frequency loop runs against the behavioural plant
`timescale 1ns/100ps
module boost_converter_switch_control_tb_top;
   import boost_ctrl_pkg::*;
   logic clk, rst, wr, rd, batt, gsuv, lsuv, drv, miss, bkp, vf, run, req, inj, clr;
   logic gate, above, settled, neg, launch;
   logic [9:0] addr;
   logic [15:0] wdat, rdat;
   logic [7:0] level;
   cur_levels_t lvl, lvl_o;
   cmp_t cmp;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   int rises, i;
   // Pin set {batt, lsuv, drv, miss, bkp} and expected gate
   logic [5:0] tbl [5] = '{6'h08, 6'h38, 6'h21, 6'h2C, 6'h2F};

   boost_converter_switch_control boost_converter_switch_control_i (
      .CLOCK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdat),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .BATT_OK_I(batt),
      .GATE_SUPPLY_UNDERVOLTAGE_I(gsuv), .LOGIC_SUPPLY_UNDERVOLTAGE_I(lsuv),
      .DRIVE_ENABLE_I(drv), .CLOCK_MISSING_I(miss), .ON_BACKUP_CLOCK_I(bkp),
      .BOOST_CMP_I(cmp), .VAR_FREQ_MODE_I(vf), .BOOST_RUN_I(run),
      .CHANNEL_SWITCH_REQUEST_I(req), .CUR_LEVELS_I(lvl),
      .SWITCH_GATE_COMMAND_O(gate), .CUR_LEVELS_O(lvl_o), .BOOST_LEVEL_O(level),
      .BOOST_ABOVE_O(above), .FILTER_SETTLED_O(settled),
      .NEG_OVERCURRENT_O(neg), .CODE_LAUNCH_O(launch));

   boost_plant boost_plant_i (.clk_i(clk), .clr_i(clr), .gate_i(gate),
      .inject_i(inj), .cmp_o(cmp));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         err_total++;
         end_of_test();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wreg(input logic [9:0] a, input logic [15:0] d);
      addr = a;
      wdat = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask : wreg

   task automatic rreg(input logic [9:0] a, input logic [15:0] exp);
      addr = a;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(1);
      chk(rdat, exp);
   endtask : rreg

   task automatic apply(input logic [4:0] v);
      {batt, lsuv, drv, miss, bkp} = v;
   endtask : apply

   task automatic count_rises(input int n);
      logic prev;
      rises = 0;
      repeat (n)
      begin
         prev = gate;
         tick(1);
         if (gate === 1'b1 && prev === 1'b0)
            rises++;
      end
   endtask : count_rises

   initial
   begin
      {wr, rd, gsuv, lsuv, miss, bkp, vf, run, req, inj} = '0;
      {rst, batt, drv, clr} = 4'hF;
      addr = '0;
      wdat = '0;
      lvl = 15'h4A52;
      tick(3);
      chk(16'(gate), 16'h0000);
      tick(1);
      rst = 1'b0;
      rreg(OFF_DRV_CFG, 16'h0001);
      rreg(OFF_FILTER, 16'h000A);
      rreg(OFF_CLK_HANDLING, 16'h0001);
      rreg(10'h3FF, 16'h0000);
      wreg(OFF_LEVEL, 16'h0040);
      chk(16'(level), 16'h0040);
      rreg(OFF_LEVEL, 16'h0040);
      wreg(OFF_FILTER, 16'h0105);
      rreg(OFF_FILTER, 16'h0105);
      req = 1'b1;
      tick(100);
      chk(16'(gate), 16'h0000);
      chk(16'(launch), 16'h0000);
      wreg(OFF_LAUNCH_B, 16'h0001);
      chk(16'(launch), 16'h0001);
      tick(2);
      chk(16'(gate), 16'h0001);
      req = 1'b0;
      tick(1);
      chk(16'(gate), 16'h0000);
      req = 1'b1;
      tick(1);
      chk(16'(gate), 16'h0001);
      for (i = 0; i < 5; i++)
      begin
         apply(tbl[i][5:1]);
         tick(4);
         chk(16'(gate), 16'(tbl[i][0]));
         apply(5'b10100);
         tick(4);
         chk(16'(gate), 16'h0001);
      end
      wreg(OFF_DRV_CFG, 16'h0000);
      apply(5'b10000);
      tick(4);
      chk(16'(gate), 16'h0000);
      wreg(OFF_DRV_CFG, 16'h0001);
      wreg(OFF_CLK_HANDLING, 16'h0000);
      apply(5'b10110);
      tick(4);
      chk(16'(gate), 16'h0001);
      rreg(OFF_CLK_HANDLING, 16'h0002);
      wreg(OFF_CLK_HANDLING, 16'h0001);
      apply(5'b10100);
      gsuv = 1'b1;
      tick(4);
      chk(16'(gate), 16'h0000);
      gsuv = 1'b0;
      tick(30);
      chk(16'(gate), 16'h0000);
      tick(50);
      chk(16'(gate), 16'h0001);
      lvl = 15'h2D6B;
      tick(1);
      chk(16'(lvl_o), 16'(lvl));
      inj = 1'b1;
      tick(4);
      chk(16'(neg), 16'h0000);
      vf = 1'b1;
      tick(4);
      chk(16'(neg), 16'h0001);
      inj = 1'b0;
      req = 1'b0;
      clr = 1'b0;
      run = 1'b1;
      count_rises(150);
      chk(16'(rises > 1), 16'h0001);
      for (i = 0; i < 3000 && above !== 1'b1; i++)
         tick(1);
      chk(16'(above), 16'h0001);
      count_rises(60);
      chk(16'(rises), 16'h0000);
      chk(16'(gate), 16'h0000);
      wreg(OFF_LEVEL, 16'h0041);
      chk(16'(settled), 16'h0000);
      tick(8);
      chk(16'(settled), 16'h0001);
      clr = 1'b1;
      tick(4);
      chk(16'(above), 16'h0000);
      tick(2);
      chk(16'(gate), 16'h0001);
      end_of_test();
   end
endmodule : boost_converter_switch_control_tb_top
